// ---- rtl/dtlb_readout_faults.sv ----
// Data TLB array, debug readout registers and translation fault detection
`timescale 1ns/10ps
`include "dtlb_defines.svh"
module dtlb_readout_faults #(
    parameter int ENTRIES = 32,
    parameter int IW = 5
) (
    input wire logic clk, // Core clock
    input wire logic rst, // Async reset, high
    input wire logic spr_wr, // Special register write strobe
    input wire logic spr_rd, // Special register read strobe
    input wire logic [9:0] spr_addr, // Special register number
    input wire logic [31:0] spr_wdata, // Write data
    output logic [31:0] spr_rdata, // Read data, one cycle after strobe
    input wire logic [IW-1:0] data_entry_index, // Entry to snapshot
    input wire logic [3:0] current_space_field, // Current space tag
    input wire logic ld_en, // Entry load strobe
    input wire logic [IW-1:0] ld_index, // Entry to load
    input wire logic [31:0] ld_tag, // Tag word, tag layout
    input wire logic [31:0] ld_tr0, // Translation word 0, plain group
    input wire logic [31:0] ld_tr1, // Translation word 1
    input wire logic data_translate_on, // Data translation enable
    input wire logic dacc_valid, // Data access request
    input wire logic [31:0] dacc_ea, // Effective address
    input wire logic dacc_write, // Access writes
    input wire logic dacc_priv, // Supervisor access
    output logic dacc_done, // Access translated, pulse
    output logic [31:0] dacc_phys, // Physical address
    output logic dacc_write_thru, // Writethrough policy
    output logic dacc_guarded, // Guarded storage
    output logic dacc_inhibit, // Cache inhibited
    output logic dtlb_miss_irq, // Data TLB miss, pulse
    output logic dtlb_error_irq, // Data TLB error, pulse
    output dtlb_pkg::dfault_t dtlb_cause, // Data storage status
    input wire logic fetch_translate_on, // Fetch translation enable
    input wire logic ifetch_valid, // Fetch request
    input wire logic itlb_hit, // Instruction TLB hit
    input wire logic itlb_page_valid, // Segment and page valid
    input wire logic itlb_prot_viol, // Fetch protection failed
    input wire logic itlb_guarded, // Fetch page guarded
    output logic itlb_miss_irq, // Instruction TLB miss, pulse
    output logic itlb_error_irq, // Instruction TLB error, pulse
    output dtlb_pkg::ifault_t itlb_cause // Cause for save/restore reg
);
    logic [31:0] tag_mem [ENTRIES];
    logic [31:0] tr0_mem [ENTRIES];
    logic [31:0] tr1_mem [ENTRIES];
    logic [ENTRIES-1:0] loaded_r;
    logic [31:0] tag_ro_r;
    logic [31:0] tr0_ro_r;
    logic [31:0] tr1_ro_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic done_r;
    logic [31:0] phys_r;
    logic wt_r;
    logic g_r;
    logic ci_r;
    logic dmiss_r;
    logic derr_r;
    dtlb_pkg::dfault_t dcause_r;
    dtlb_pkg::dfault_t dcause_nxt;
    logic imiss_r;
    logic ierr_r;
    dtlb_pkg::ifault_t icause_r;
    dtlb_pkg::ifault_t icause_nxt;

    dtlb_check_if cif ();

    function automatic logic [19:0] size_mask(input logic [2:0] code);
        logic [19:0] m;
        m = `MASK_4K;
        unique case (dtlb_pkg::page_size_t'(code))
            dtlb_pkg::SZ_16K: m = `MASK_16K;
            dtlb_pkg::SZ_512K: m = `MASK_512K;
            dtlb_pkg::SZ_8M: m = `MASK_8M;
            default: m = `MASK_4K;
        endcase
        return m;
    endfunction : size_mask // RULE6

    // Entry load: group stored inverted, reserved bits forced clear
    wire [31:0] tr0_in = (ld_tr0 ^ `T0_APG_MASK) & ~`T0_RSV_MASK; // RULE8
    wire [31:0] tr1_in = ld_tr1 & ~`T1_RSV_MASK; // RULE11

    // The array is not cleared by reset; loaded_r keeps stale entries out
    always_ff @(posedge clk) begin
        if (ld_en) begin
            tag_mem[ld_index] <= ld_tag;
            tr0_mem[ld_index] <= tr0_in;
            tr1_mem[ld_index] <= tr1_in;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loaded_r <= '0;
        end else if (ld_en) begin
            loaded_r[ld_index] <= 1'b1;
        end
    end

    // Per-entry match
    logic [ENTRIES-1:0] match;
    genvar e;
    generate
        for (e = 0; e < ENTRIES; e++) begin : g_match
            wire [19:0] msk = size_mask(tag_mem[e][`TAG_SIZE_HI:`TAG_SIZE_LO]);
            wire [19:0] diff =
                tag_mem[e][`TAG_EPN_HI:`TAG_EPN_LO] ^ dacc_ea[31:12];
            wire space_ok = tag_mem[e][`TAG_GLOBAL] ||
                (tag_mem[e][`TAG_SPACE_HI:`TAG_SPACE_LO] ==
                 current_space_field); // RULE7
            assign match[e] = loaded_r[e] && ((diff & msk) == 20'h00000)
                && space_ok;
        end
    endgenerate

    // Lowest matching index wins; software should avoid double hits
    logic hit;
    logic [IW-1:0] hit_idx;
    always_comb begin
        hit = 1'b0;
        hit_idx = '0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (match[i]) begin
                hit = 1'b1;
                hit_idx = IW'(i);
            end
        end
    end

    wire [31:0] h_tag = tag_mem[hit_idx];
    wire [31:0] h_tr0 = tr0_mem[hit_idx];
    wire [31:0] h_tr1 = tr1_mem[hit_idx];
    wire [19:0] h_mask = size_mask(h_tr0[`T0_SIZE_HI:`T0_SIZE_LO]);
    wire [19:0] h_page =
        (h_tr0[`T0_PPN_HI:`T0_PPN_LO] & h_mask) | (dacc_ea[31:12] & ~h_mask);

    assign cif.tag = h_tag;
    assign cif.tr0 = h_tr0;
    assign cif.tr1 = h_tr1;
    assign cif.sub = dacc_ea[11:10];
    assign cif.write = dacc_write;
    assign cif.priv = dacc_priv;

    dtlb_access_check dtlb_access_check_i (
        .cif(cif)
    );

    // Data access classification
    wire d_req = dacc_valid && data_translate_on;
    wire d_miss = d_req && !hit; // RULE17
    wire d_fault = cif.invalid || cif.protect || cif.modified;
    wire d_err = d_req && hit && d_fault; // RULE20
    wire d_ok = dacc_valid && !d_miss && !d_err;
    wire [31:0] d_phys = data_translate_on ? {h_page, dacc_ea[11:0]}
                                           : dacc_ea;

    // Instruction side classification
    wire i_req = ifetch_valid && fetch_translate_on;
    wire i_miss = i_req && !itlb_hit; // RULE16
    wire i_err = i_req && itlb_hit &&
        (!itlb_page_valid || itlb_prot_viol || itlb_guarded); // RULE18

    // A new fault overrides a software clear in the same cycle
    wire dstat_clr = spr_wr && (spr_addr == `SPR_DSTAT);
    wire istat_clr = spr_wr && (spr_addr == `SPR_ISTAT);
    always_comb begin
        dcause_nxt = dcause_r;
        if (d_err) begin
            dcause_nxt.invalid = cif.invalid;
            dcause_nxt.protect = cif.protect;
            dcause_nxt.modified = cif.modified;
            dcause_nxt.store = dacc_write;
        end else if (dstat_clr) begin
            dcause_nxt = '0;
        end
    end // RULE21

    always_comb begin
        icause_nxt = icause_r;
        if (i_err) begin
            icause_nxt.invalid = !itlb_page_valid;
            icause_nxt.protect = itlb_prot_viol;
            icause_nxt.guarded = itlb_guarded;
        end else if (istat_clr) begin
            icause_nxt = '0;
        end
    end // RULE19

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_r <= 1'b0;
            dmiss_r <= 1'b0;
            derr_r <= 1'b0;
            imiss_r <= 1'b0;
            ierr_r <= 1'b0;
            dcause_r <= '0;
            icause_r <= '0;
        end else begin
            done_r <= d_ok;
            dmiss_r <= d_miss;
            derr_r <= d_err;
            imiss_r <= i_miss;
            ierr_r <= i_err;
            dcause_r <= dcause_nxt;
            icause_r <= icause_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phys_r <= 32'h0000_0000;
            wt_r <= 1'b0;
            g_r <= 1'b0;
            ci_r <= 1'b0;
        end else if (d_ok) begin
            phys_r <= d_phys;
            wt_r <= data_translate_on && h_tr0[`T0_WTHRU]; // RULE10
            g_r <= data_translate_on && h_tr0[`T0_G]; // RULE9
            ci_r <= data_translate_on && h_tr0[`T0_CI];
        end
    end

    // Snapshot on any tag readout write; the write data is never used.
    // A reset value is given only so reads after reset are not unknown.
    wire snap = spr_wr && (spr_addr == `SPR_TAG_RD); // RULE2
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tag_ro_r <= 32'h0000_0000; // RULE4
            tr0_ro_r <= 32'h0000_0000;
            tr1_ro_r <= 32'h0000_0000;
        end else if (snap) begin
            tag_ro_r <= tag_mem[data_entry_index]; // RULE1
            tr0_ro_r <= tr0_mem[data_entry_index] & ~`T0_RSV_MASK; // RULE11
            tr1_ro_r <= tr1_mem[data_entry_index] & ~`T1_RSV_MASK;
        end
    end
    // Writes to the translation readouts decode to nothing at all  RULE3

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (spr_addr)
            `SPR_TAG_RD: rdata_nxt = tag_ro_r; // RULE23
            `SPR_TR0_RD: rdata_nxt = tr0_ro_r;
            `SPR_TR1_RD: rdata_nxt = tr1_ro_r;
            `SPR_DSTAT: rdata_nxt = {28'h0000000, dcause_r};
            `SPR_ISTAT: rdata_nxt = {29'h0000000, icause_r};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (spr_rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    // Handler dispatch after an error is left to software  RULE22
    assign spr_rdata = rdata_r;
    assign dacc_done = done_r;
    assign dacc_phys = phys_r;
    assign dacc_write_thru = wt_r;
    assign dacc_guarded = g_r;
    assign dacc_inhibit = ci_r;
    assign dtlb_miss_irq = dmiss_r;
    assign dtlb_error_irq = derr_r;
    assign dtlb_cause = dcause_r;
    assign itlb_miss_irq = imiss_r;
    assign itlb_error_irq = ierr_r;
    assign itlb_cause = icause_r;
endmodule : dtlb_readout_faults

// ---- rtl/dtlb_defines.svh ----
// Special register numbers, field positions and masks of the data TLB block
// Notes on behaviour
// RULE1: Writing the tag readout register snapshots the indexed entry.
// RULE2: The written data is ignored; only the write event counts.
// RULE3: Writes to both translation readout registers do nothing.
// RULE4: Readout registers need no reset value before the first snapshot.
// RULE5: Tag readout bits 20-23 are subpage valid flags, subpage 0 first.
// RULE6: Page size codes: 000 4K, 001 16K, 011 512K, 111 8M.
// RULE7: Unshared entries hit only when their space tag equals current space.
// RULE8: Protection group is shown as its one's complement.
// RULE9: Guard bit: 0 unguarded, 1 guarded storage.
// RULE10: Cache policy bit: 0 copyback, 1 writethrough.
// RULE11: Reserved translation readout bits read as zero.
// RULE12: Write to an unmodified page faults instead of completing.
// RULE13: Four privileged access bits, one per subpage, at bits 19-22.
// RULE14: Privileged access type 0 means read only, 1 read and write.
// RULE15: User reads and writes need their per-subpage permission bit.
// RULE16: Fetch missing the instruction TLB with translation on raises miss.
// RULE17: Data access missing the data TLB with translation on raises miss.
// RULE18: Fetch error on invalid translation, protection or guarded storage.
// RULE19: Fetch error cause is recorded for the save/restore register.
// RULE20: Data error on invalid translation, protection or unmodified write.
// RULE21: Data error cause is recorded in the data storage status register.
// RULE22: Software, not hardware, dispatches the storage handler.
// RULE23: Readouts are 32-bit special registers holding the last snapshot.
`ifndef DTLB_DEFINES_SVH
`define DTLB_DEFINES_SVH

`define SPR_TAG_RD 10'h318
`define SPR_TR0_RD 10'h319
`define SPR_TR1_RD 10'h31A
`define SPR_DSTAT 10'h31B
`define SPR_ISTAT 10'h31C

`define TAG_EPN_HI 31
`define TAG_EPN_LO 12
`define TAG_SPV_HI 11
`define TAG_SPV_LO 8
`define TAG_SIZE_HI 7
`define TAG_SIZE_LO 5
`define TAG_GLOBAL 4
`define TAG_SPACE_HI 3
`define TAG_SPACE_LO 0

`define T0_PPN_HI 31
`define T0_PPN_LO 12
`define T0_SIZE_HI 11
`define T0_SIZE_LO 9
`define T0_APG_MASK 32'h0000_01E0
`define T0_G 4
`define T0_WTHRU 3
`define T0_CI 2
`define T0_RSV_MASK 32'h0000_0003

`define T1_RSV_MASK 32'hFFFF_8000
`define T1_C 14
`define T1_EVALID 13
`define T1_PRIV_HI 12
`define T1_PRIV_LO 9
`define T1_PRIV_WR 8
`define T1_USER_RD0 7

`define MASK_4K 20'hFFFFF
`define MASK_16K 20'hFFFFC
`define MASK_512K 20'hFFF80
`define MASK_8M 20'hFF800

`endif

// ---- rtl/dtlb_pkg.sv ----
// Types shared by the data TLB block
package dtlb_pkg;
    typedef enum logic [2:0] {
        SZ_4K = 3'h0,
        SZ_16K = 3'h1,
        SZ_512K = 3'h3,
        SZ_8M = 3'h7
    } page_size_t;

    typedef struct packed {
        logic store;
        logic modified;
        logic protect;
        logic invalid;
    } dfault_t;

    typedef struct packed {
        logic guarded;
        logic protect;
        logic invalid;
    } ifault_t;
endpackage : dtlb_pkg

// ---- rtl/dtlb_check_if.sv ----
// Carrier between the lookup and the permission checker
`timescale 1ns/10ps
interface dtlb_check_if;
    logic [31:0] tag;
    logic [31:0] tr0;
    logic [31:0] tr1;
    logic [1:0] sub;
    logic write;
    logic priv;
    logic invalid;
    logic protect;
    logic modified;
    modport req (output tag, tr0, tr1, sub, write, priv,
                 input invalid, protect, modified);
    modport chk (input tag, tr0, tr1, sub, write, priv,
                 output invalid, protect, modified);
endinterface : dtlb_check_if

// ---- rtl/dtlb_access_check.sv ----
// Subpage validity, protection and modified checks on one entry
`timescale 1ns/10ps
`include "dtlb_defines.svh"
module dtlb_access_check (
    dtlb_check_if.chk cif // Matched entry and access
);
    wire [3:0] spv;
    wire [3:0] pr;
    wire [3:0] ur;
    wire [3:0] uw;
    wire [1:0] pick;
    wire pr_ok;
    wire user_ok;

    assign spv = cif.tag[`TAG_SPV_HI:`TAG_SPV_LO]; // RULE5
    assign pr = cif.tr1[`T1_PRIV_HI:`T1_PRIV_LO]; // RULE13
    // Subpage 0 sits in the most significant bit of each group
    assign pick = ~cif.sub;

    genvar s;
    generate
        for (s = 0; s < 4; s++) begin : g_user
            assign ur[3-s] = cif.tr1[`T1_USER_RD0-2*s];
            assign uw[3-s] = cif.tr1[`T1_USER_RD0-1-2*s];
        end
    endgenerate

    assign cif.invalid = !spv[pick] || !cif.tr1[`T1_EVALID]; // RULE20
    assign pr_ok = pr[pick] && (!cif.write || cif.tr1[`T1_PRIV_WR]); // RULE14
    assign user_ok = cif.write ? uw[pick] : ur[pick]; // RULE15
    assign cif.protect = cif.priv ? !pr_ok : !user_ok; // RULE20
    assign cif.modified = cif.write && !cif.tr1[`T1_C]; // RULE12
endmodule : dtlb_access_check

// ---- dv/dtlb_readout_faults_sva.sv ----
// Concurrent checks on the data TLB readout and fault ports
`timescale 1ns/10ps
`include "dtlb_defines.svh"
module dtlb_readout_faults_sva (
    input wire logic clk, // Core clock
    input wire logic rst, // Async reset, high
    input wire logic spr_rd, // Read strobe
    input wire logic [9:0] spr_addr, // Register number
    input wire logic [31:0] spr_rdata, // Read data
    input wire logic data_translate_on, // Data translation
    input wire logic dacc_valid, // Data access
    input wire logic [31:0] dacc_ea, // Access address
    input wire logic dacc_write, // Access writes
    input wire logic dacc_done, // Translated
    input wire logic [31:0] dacc_phys, // Physical address
    input wire logic dacc_write_thru, // Writethrough
    input wire logic dacc_guarded, // Guarded
    input wire logic dtlb_miss_irq, // Data miss
    input wire logic dtlb_error_irq, // Data error
    input dtlb_pkg::dfault_t dtlb_cause, // Data cause
    input wire logic fetch_translate_on, // Fetch translation
    input wire logic ifetch_valid, // Fetch request
    input wire logic itlb_hit, // Fetch hit
    input wire logic itlb_page_valid, // Fetch page valid
    input wire logic itlb_prot_viol, // Fetch protection
    input wire logic itlb_guarded, // Fetch guarded
    input wire logic itlb_miss_irq, // Fetch miss
    input wire logic itlb_error_irq, // Fetch error
    input dtlb_pkg::ifault_t itlb_cause // Fetch cause
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic [2:0] d_out = {dtlb_error_irq, dtlb_miss_irq, dacc_done};

    one_outcome_a: assert property (dacc_valid |=> $onehot(d_out))
        else $error("data access outcome not unique");
    quiet_idle_a: assert property (!dacc_valid |=> d_out == 3'h0)
        else $error("data outcome without access");
    untranslated_a: assert property (dacc_valid && !data_translate_on
        |=> dacc_done && dacc_phys == $past(dacc_ea) && !dacc_guarded
        && !dacc_write_thru) else $error("untranslated access wrong");
    err_cause_a: assert property (dtlb_error_irq
        |-> dtlb_cause[2:0] != 3'h0 && dtlb_cause.store == $past(dacc_write))
        else $error("data error cause wrong");
    dirty_write_a: assert property (dtlb_error_irq
        && dtlb_cause.modified |-> $past(dacc_write) && $past(dacc_valid))
        else $error("modified fault without write");
    fetch_miss_a: assert property (ifetch_valid && fetch_translate_on
        && !itlb_hit |=> itlb_miss_irq && !itlb_error_irq)
        else $error("fetch miss not raised");
    fetch_err_a: assert property (ifetch_valid
        && fetch_translate_on && itlb_hit
        && (!itlb_page_valid || itlb_prot_viol || itlb_guarded)
        |=> itlb_error_irq && itlb_cause.guarded == $past(itlb_guarded)
        && itlb_cause.protect == $past(itlb_prot_viol)
        && itlb_cause.invalid == !$past(itlb_page_valid))
        else $error("fetch error wrong");
    fetch_off_a: assert property (ifetch_valid && !fetch_translate_on
        |=> !itlb_miss_irq && !itlb_error_irq)
        else $error("fetch fault with translation off");
    rdata_hold_a: assert property (!spr_rd |=> $stable(spr_rdata))
        else $error("read data changed without read");
    tr0_resv_a: assert property (spr_rd && spr_addr == `SPR_TR0_RD
        |=> spr_rdata[1:0] == 2'h0) else $error("reserved bits set");
    tr1_resv_a: assert property (spr_rd && spr_addr == `SPR_TR1_RD
        |=> spr_rdata[31:15] == 17'h0) else $error("reserved bits set");
endmodule : dtlb_readout_faults_sva

bind dtlb_readout_faults dtlb_readout_faults_sva dtlb_readout_faults_sva_i (
    .clk, .rst, .spr_rd, .spr_addr, .spr_rdata, .data_translate_on,
    .dacc_valid, .dacc_ea, .dacc_write, .dacc_done, .dacc_phys,
    .dacc_write_thru, .dacc_guarded, .dtlb_miss_irq, .dtlb_error_irq,
    .dtlb_cause, .fetch_translate_on, .ifetch_valid, .itlb_hit,
    .itlb_page_valid, .itlb_prot_viol, .itlb_guarded, .itlb_miss_irq,
    .itlb_error_irq, .itlb_cause);

// ---- dv/itlb_answer_model.sv ----
// Instruction side translation answers for the fetch pipeline
`timescale 1ns/10ps
module itlb_answer_model (
    input wire logic clk, // Core clock
    input wire logic ifetch_valid, // Fetch request
    input wire logic [31:0] fetch_ea, // Fetch address
    output logic itlb_hit, // Page found
    output logic itlb_page_valid, // Segment and page valid
    output logic itlb_prot_viol, // Protection failed
    output logic itlb_guarded // Guarded page
);
    logic tog_r = 1'b0;
    wire logic [1:0] pg = fetch_ea[13:12];
    // Outside a request the answers wander so stale values never help
    always @(posedge clk) tog_r <= ~tog_r;
    // Only answers; handler dispatch stays with software
    assign itlb_hit = ifetch_valid ? fetch_ea[31:14] == 18'h0 : tog_r;
    assign itlb_page_valid = ifetch_valid ? pg != 2'h1 : ~tog_r;
    assign itlb_prot_viol = ifetch_valid ? pg == 2'h2 : tog_r;
    assign itlb_guarded = ifetch_valid ? pg == 2'h3 : ~tog_r;
endmodule : itlb_answer_model

// ---- dv/dtlb_readout_faults_tb_top.sv ----
// Directed bench for the data TLB readout and fault block
`timescale 1ns/10ps
`include "dtlb_defines.svh"
module dtlb_readout_faults_tb_top;
    logic clk = 1'b0, rst = 1'b1, spr_wr = 1'b0, spr_rd = 1'b0;
    logic ld_en = 1'b0, dacc_valid = 1'b0, dacc_write = 1'b0;
    logic dacc_priv = 1'b0, data_translate_on = 1'b0;
    logic fetch_translate_on = 1'b0, ifetch_valid = 1'b0;
    logic [9:0] spr_addr = 10'h0;
    logic [31:0] spr_wdata = 32'h0, ld_tag = 32'h0, ld_tr0 = 32'h0;
    logic [31:0] ld_tr1 = 32'h0, dacc_ea = 32'h0, fetch_ea = 32'h0;
    logic [31:0] spr_rdata, dacc_phys;
    logic [4:0] data_entry_index = 5'h0, ld_index = 5'h0;
    logic [3:0] current_space_field = 4'h5;
    logic dacc_done, dacc_write_thru, dacc_guarded, dacc_inhibit;
    logic dtlb_miss_irq, dtlb_error_irq, itlb_miss_irq, itlb_error_irq;
    logic itlb_hit, itlb_page_valid, itlb_prot_viol, itlb_guarded;
    dtlb_pkg::dfault_t dtlb_cause;
    dtlb_pkg::ifault_t itlb_cause;
    int n_errors = 0, n_compared = 0;

    dtlb_readout_faults dtlb_readout_faults_i (.clk, .rst, .spr_wr, .spr_rd,
        .spr_addr, .spr_wdata, .spr_rdata, .data_entry_index,
        .current_space_field, .ld_en, .ld_index, .ld_tag, .ld_tr0, .ld_tr1,
        .data_translate_on, .dacc_valid, .dacc_ea, .dacc_write, .dacc_priv,
        .dacc_done, .dacc_phys, .dacc_write_thru, .dacc_guarded,
        .dacc_inhibit, .dtlb_miss_irq, .dtlb_error_irq, .dtlb_cause,
        .fetch_translate_on, .ifetch_valid, .itlb_hit, .itlb_page_valid,
        .itlb_prot_viol, .itlb_guarded, .itlb_miss_irq, .itlb_error_irq,
        .itlb_cause);
    itlb_answer_model itlb_answer_model_i (.clk, .ifetch_valid, .fetch_ea,
        .itlb_hit, .itlb_page_valid, .itlb_prot_viol, .itlb_guarded);

    always #20 clk = ~clk;

    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    task automatic cmp(input string what, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic reg_write(input logic [9:0] a);
        tick;
        spr_wr = 1'b1;
        spr_addr = a;
        // Junk data each time: the write event alone must act
        spr_wdata = ~spr_wdata ^ 32'h5A5A_0F0F;
        tick;
        spr_wr = 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [9:0] a, input logic [31:0] exp);
        tick;
        spr_rd = 1'b1;
        spr_addr = a;
        tick;
        spr_rd = 1'b0;
        cmp($sformatf("register %h", a), exp, spr_rdata);
    endtask : reg_read

    task automatic load(input logic [4:0] i, input logic [31:0] t, a, b);
        tick;
        ld_en = 1'b1;
        ld_index = i;
        ld_tag = t;
        ld_tr0 = a;
        ld_tr1 = b;
        tick;
        ld_en = 1'b0;
    endtask : load

    // exp: 1 done, 2 miss, 4 error; v is the address or the cause
    task automatic da(input logic [31:0] ea, input logic w, p,
                      input logic [2:0] exp, input logic [31:0] v);
        tick;
        dacc_valid = 1'b1;
        dacc_ea = ea;
        dacc_write = w;
        dacc_priv = p;
        tick;
        dacc_valid = 1'b0;
        cmp("data outcome", 32'(exp),
            32'({dtlb_error_irq, dtlb_miss_irq, dacc_done}));
        if (exp == 3'h1) cmp("dacc_phys", v, dacc_phys);
        if (exp == 3'h4) cmp("dtlb_cause", v, 32'(dtlb_cause));
    endtask : da

    task automatic fe(input logic [31:0] ea, input logic [1:0] exp,
                      input logic [2:0] c);
        tick;
        ifetch_valid = 1'b1;
        fetch_ea = ea;
        tick;
        ifetch_valid = 1'b0;
        cmp("fetch outcome", 32'(exp), 32'({itlb_error_irq, itlb_miss_irq}));
        if (exp == 2'h2) cmp("itlb_cause", 32'(c), 32'(itlb_cause));
    endtask : fe

    task automatic summarize;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        summarize;
    end

    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        load(5'h00, 32'h0001_0D05, 32'hABCD_E07B, 32'hFFFF_FCB3);
        load(5'h1F, 32'h0002_0F39, 32'h1234_0204, 32'h0000_3FFF);
        reg_write(`SPR_TAG_RD);
        reg_read(`SPR_TAG_RD, 32'h0001_0D05);
        reg_read(`SPR_TR0_RD, 32'hABCD_E198);
        reg_read(`SPR_TR1_RD, 32'h0000_7CB3);
        data_entry_index = 5'h1F;
        reg_write(`SPR_TR0_RD);
        reg_write(`SPR_TR1_RD);
        reg_read(`SPR_TR0_RD, 32'hABCD_E198);
        reg_read(`SPR_TR1_RD, 32'h0000_7CB3);
        reg_write(`SPR_TAG_RD);
        load(5'h1F, 32'h0, 32'h0, 32'h0);
        reg_read(`SPR_TAG_RD, 32'h0002_0F39);
        reg_read(`SPR_TR0_RD, 32'h1234_03E4);
        reg_read(`SPR_TR1_RD, 32'h0000_3FFF);
        reg_read(10'h100, 32'h0);
        load(5'h1F, 32'h0002_0F39, 32'h1234_0204, 32'h0000_3FFF);
        data_translate_on = 1'b1;
        da(32'h0001_0123, 1'b0, 1'b1, 3'h1, 32'hABCD_E123);
        cmp("attrs", 32'h6, 32'({dacc_write_thru, dacc_guarded,
            dacc_inhibit}));
        da(32'h0001_0800, 1'b0, 1'b1, 3'h4, 32'h1);
        da(32'h0001_0C00, 1'b0, 1'b1, 3'h4, 32'h2);
        da(32'h0001_0000, 1'b1, 1'b1, 3'h4, 32'hA);
        da(32'h0001_0000, 1'b1, 1'b0, 3'h4, 32'hA);
        da(32'h0001_0000, 1'b0, 1'b0, 3'h1, 32'hABCD_E000);
        da(32'h0001_0400, 1'b1, 1'b0, 3'h1, 32'hABCD_E400);
        da(32'h0002_0000, 1'b1, 1'b1, 3'h4, 32'hC);
        reg_read(`SPR_DSTAT, 32'hC);
        reg_write(`SPR_DSTAT);
        reg_read(`SPR_DSTAT, 32'h0);
        current_space_field = 4'h6;
        da(32'h0001_0123, 1'b0, 1'b1, 3'h2, 32'h0);
        da(32'h0002_3ABC, 1'b0, 1'b1, 3'h1, 32'h1234_3ABC);
        cmp("attrs 16K", 32'h1, 32'({dacc_write_thru, dacc_guarded,
            dacc_inhibit}));
        da(32'h0005_0000, 1'b0, 1'b1, 3'h2, 32'h0);
        data_translate_on = 1'b0;
        da(32'h0005_0000, 1'b1, 1'b0, 3'h1, 32'h0005_0000);
        cmp("attrs off", 32'h0, 32'({dacc_write_thru, dacc_guarded,
            dacc_inhibit}));
        fetch_translate_on = 1'b1;
        fe(32'h0000_0000, 2'h0, 3'h0);
        fe(32'h0004_0000, 2'h1, 3'h0);
        fe(32'h0000_1000, 2'h2, 3'h1);
        fe(32'h0000_2000, 2'h2, 3'h2);
        fe(32'h0000_3000, 2'h2, 3'h4);
        reg_read(`SPR_ISTAT, 32'h4);
        fetch_translate_on = 1'b0;
        fe(32'h0000_3000, 2'h0, 3'h0);
        // A second reset forgets every entry, so lookups miss again
        rst = 1'b1;
        tick;
        rst = 1'b0;
        data_translate_on = 1'b1;
        da(32'h0001_0123, 1'b0, 1'b1, 3'h2, 32'h0);
        summarize;
    end
endmodule : dtlb_readout_faults_tb_top
